// ==== hdl/sram_host_pkg.sv ====
package sram_host_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // pin widths
   localparam int WORD_ADDR_W = 19;
   localparam int DATA_W      = 16;
   localparam int LANE_W      = 8;
   localparam int LANES       = 2;
   localparam int USER_ADDR_W = WORD_ADDR_W + 1;
   localparam int CNT_W       = 4;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_ACCESS_NS   = 45;
   localparam int T_WRITE_NS    = 45;
   localparam int SYNC_STAGES   = 2;
   // least times round up to whole cycles
   localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_STAGES;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [DATA_W-1:0]      RST_DATA  = 16'h0000;
   localparam logic [WORD_ADDR_W-1:0] RST_ADDR  = 19'h00000;
   localparam logic [CNT_W-1:0]       RST_CNT   = 4'h0;
   localparam logic [LANES-1:0]       LANES_OFF = 2'h3;
   localparam logic [LANES-1:0]       LANES_ON  = 2'h0;
   localparam logic [LANE_W-1:0]      BYTE_ZERO = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_RD_WAIT  = 5'h02,
      ST_WR_SETUP = 5'h04,
      ST_WR_PULSE = 5'h08,
      ST_WR_HOLD  = 5'h10
   } ctl_state_e;

endpackage : sram_host_pkg

// ==== hdl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;

   sync_s q;
   sync_s d;

   always_comb begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule : pin_sync
`default_nettype wire

// ==== hdl/sram_host_ctl.sv ====
// How it works
// - write: selects active, strobe low, address, data
// - read: selects active, output enable low, strobe high
// - strap high selects 512K by 16
// - strap low: 1M by 8, extra address bit
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctl (
   input  wire logic                                   clk_sys,
   input  wire logic                                   resetn,
   // user side
   input  wire logic                                   wide_mode,
   input  wire logic                                   req_valid,
   output logic                                        req_ready,
   input  wire logic                                   req_write,
   input  wire logic [sram_host_pkg::USER_ADDR_W-1:0]  req_addr,
   input  wire logic [sram_host_pkg::DATA_W-1:0]       req_wdata,
   input  wire logic [sram_host_pkg::LANES-1:0]        req_lanes,
   output logic                                        rsp_valid,
   output logic      [sram_host_pkg::DATA_W-1:0]       rsp_rdata,
   // memory pins
   output logic      [sram_host_pkg::WORD_ADDR_W-1:0]  word_address,
   output logic                                        extra_address_bit,
   output logic                                        select_low_active,
   output logic                                        select_high_active,
   output logic                                        out_en_n,
   output logic                                        write_en_n,
   output logic                                        upper_lane_en_n,
   output logic                                        lower_lane_en_n,
   output logic                                        width_sel,
   input  wire logic [sram_host_pkg::DATA_W-1:0]       data_lines_i,
   output logic      [sram_host_pkg::DATA_W-1:0]       data_lines_o,
   output logic                                        data_lines_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      sram_host_pkg::ctl_state_e                   st;
      logic [sram_host_pkg::CNT_W-1:0]             cnt;
      logic                                        ready;
      logic                                        rvalid;
      logic [sram_host_pkg::DATA_W-1:0]            rdata;
      logic [sram_host_pkg::WORD_ADDR_W-1:0]       addr;
      logic                                        xbit;
      logic                                        sel_n;
      logic                                        sel_h;
      logic                                        oe_n;
      logic                                        we_n;
      logic [sram_host_pkg::LANES-1:0]             lanes_n;
      logic                                        wide;
      logic [sram_host_pkg::DATA_W-1:0]            dout;
      logic                                        doe;
   } ctl_s;

   ctl_s                              q;
   ctl_s                              d;
   logic [sram_host_pkg::DATA_W-1:0]  rd_sync;

   pin_sync #(
      .W (sram_host_pkg::DATA_W)
   ) u_rd_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (data_lines_i),
      .dout    (rd_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read data
   // a lane left disabled reads back as zero, whatever floats on its pins
   function automatic logic [sram_host_pkg::LANE_W-1:0] lane_byte(
      input logic                             en_n,
      input logic [sram_host_pkg::LANE_W-1:0] b
   );
      logic [sram_host_pkg::LANE_W-1:0] r;
      r = sram_host_pkg::BYTE_ZERO;
      if (!en_n) begin
         r = b;
      end
      return r;
   endfunction : lane_byte

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d        = q;
      d.rvalid = 1'b0;
      case (q.st)
         sram_host_pkg::ST_IDLE: begin
            if (req_valid && q.ready) begin
               d.ready = 1'b0;
               d.addr  = req_addr[sram_host_pkg::WORD_ADDR_W-1:0];
               d.xbit  = q.wide ? 1'b0 : req_addr[sram_host_pkg::WORD_ADDR_W];
               d.sel_n = 1'b0;
               d.sel_h = 1'b1;
               // byte mode enables both lanes, whatever req_lanes holds
               d.lanes_n = q.wide ? ~req_lanes : sram_host_pkg::LANES_ON;
               if (req_write) begin
                  d.oe_n = 1'b1;
                  d.we_n = 1'b1;
                  d.dout = req_wdata;
                  d.doe  = 1'b1;
                  d.st   = sram_host_pkg::ST_WR_SETUP;
               end else begin
                  d.oe_n = 1'b0;
                  d.we_n = 1'b1;
                  d.doe  = 1'b0;
                  d.cnt  = 4'(sram_host_pkg::READ_WAIT_CYC - 1);
                  d.st   = sram_host_pkg::ST_RD_WAIT;
               end
            end else begin
               // an access keeps the strap that its address was decoded with
               d.wide = wide_mode;
            end
         end
         sram_host_pkg::ST_RD_WAIT: begin
            if (q.cnt == sram_host_pkg::RST_CNT) begin
               d.rvalid = 1'b1;
               if (q.wide) begin
                  d.rdata[sram_host_pkg::LANE_W-1:0] =
                     lane_byte(q.lanes_n[0], rd_sync[sram_host_pkg::LANE_W-1:0]);
                  d.rdata[sram_host_pkg::DATA_W-1:sram_host_pkg::LANE_W] =
                     lane_byte(q.lanes_n[1],
                               rd_sync[sram_host_pkg::DATA_W-1:sram_host_pkg::LANE_W]);
               end else begin
                  d.rdata = {sram_host_pkg::BYTE_ZERO,
                             rd_sync[sram_host_pkg::LANE_W-1:0]};
               end
               d.sel_n   = 1'b1;
               d.sel_h   = 1'b0;
               d.oe_n    = 1'b1;
               d.lanes_n = sram_host_pkg::LANES_OFF;
               d.ready   = 1'b1;
               d.st      = sram_host_pkg::ST_IDLE;
            end else begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         sram_host_pkg::ST_WR_SETUP: begin
            // address and data settle before the strobe falls
            d.we_n = 1'b0;
            d.cnt  = 4'(sram_host_pkg::WRITE_CYC - 1);
            d.st   = sram_host_pkg::ST_WR_PULSE;
         end
         sram_host_pkg::ST_WR_PULSE: begin
            if (q.cnt == sram_host_pkg::RST_CNT) begin
               d.we_n = 1'b1;
               d.st   = sram_host_pkg::ST_WR_HOLD;
            end else begin
               d.cnt = q.cnt - 4'h1;
            end
         end
         sram_host_pkg::ST_WR_HOLD: begin
            // data held one cycle past the strobe's rise
            d.doe     = 1'b0;
            d.sel_n   = 1'b1;
            d.sel_h   = 1'b0;
            d.lanes_n = sram_host_pkg::LANES_OFF;
            d.ready   = 1'b1;
            d.st      = sram_host_pkg::ST_IDLE;
         end
         default: begin
            d.st      = sram_host_pkg::ST_IDLE;
            d.sel_n   = 1'b1;
            d.sel_h   = 1'b0;
            d.oe_n    = 1'b1;
            d.we_n    = 1'b1;
            d.doe     = 1'b0;
            d.lanes_n = sram_host_pkg::LANES_OFF;
            d.ready   = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         q.st      <= sram_host_pkg::ST_IDLE;
         q.cnt     <= sram_host_pkg::RST_CNT;
         q.ready   <= 1'b1;
         q.rvalid  <= 1'b0;
         q.rdata   <= sram_host_pkg::RST_DATA;
         q.addr    <= sram_host_pkg::RST_ADDR;
         q.xbit    <= 1'b0;
         q.sel_n   <= 1'b1;
         q.sel_h   <= 1'b0;
         q.oe_n    <= 1'b1;
         q.we_n    <= 1'b1;
         q.lanes_n <= sram_host_pkg::LANES_OFF;
         q.wide    <= 1'b1;
         q.dout    <= sram_host_pkg::RST_DATA;
         q.doe     <= 1'b0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign req_ready          = q.ready;
   assign rsp_valid          = q.rvalid;
   assign rsp_rdata          = q.rdata;
   assign word_address       = q.addr;
   assign extra_address_bit  = q.xbit;
   assign select_low_active  = q.sel_n;
   assign select_high_active = q.sel_h;
   assign out_en_n           = q.oe_n;
   assign write_en_n         = q.we_n;
   assign upper_lane_en_n    = q.lanes_n[1];
   assign lower_lane_en_n    = q.lanes_n[0];
   assign width_sel          = q.wide;
   assign data_lines_o       = q.dout;
   assign data_lines_oe      = q.doe;

endmodule : sram_host_ctl
`default_nettype wire

// ==== tb/sram_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model #(
   parameter int ACC_NS = 40
) (
   input  wire logic        clk_sys,
   input  wire logic [18:0] word_address,
   input  wire logic        extra_address_bit,
   input  wire logic        select_low_active,
   input  wire logic        select_high_active,
   input  wire logic        out_en_n,
   input  wire logic        write_en_n,
   input  wire logic        upper_lane_en_n,
   input  wire logic        lower_lane_en_n,
   input  wire logic        width_sel,
   input  wire logic [15:0] bus,
   output logic      [15:0] dq
);
   logic [15:0] mem [int];
   logic [15:0] flt = 16'hA5C3;
   logic [15:0] rd;
   logic [15:0] m;
   logic [20:0] key;
   logic        lo, hi, on;
   always_comb begin
      key = width_sel ? {2'h0, word_address} : {1'b1, extra_address_bit, word_address};
      lo  = !width_sel || !lower_lane_en_n;
      hi  = width_sel && !upper_lane_en_n;
      on  = !select_low_active && select_high_active && (lo || hi);
   end
   // released lines show a pattern that changes every cycle
   always @(posedge clk_sys) flt <= ~flt;
   always @(posedge write_en_n) begin
      if (on) begin
         if (!mem.exists(key)) mem[key] = 16'h0000;
         if (lo) mem[key][7:0] = bus[7:0];
         if (hi) mem[key][15:8] = bus[15:8];
      end
   end
   always @* begin
      rd = flt;
      m  = mem.exists(key) ? mem[key] : flt;
      if (on && !out_en_n && write_en_n) begin
         if (lo) rd[7:0] = m[7:0];
         if (hi) rd[15:8] = m[15:8];
      end
   end
   assign #(ACC_NS) dq = rd;
endmodule : sram_dev_model
`default_nettype wire

// ==== tb/sram_host_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sram_host_chk (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        wide_mode,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_write,
   input wire logic [19:0] req_addr,
   input wire logic [1:0]  req_lanes,
   input wire logic        rsp_valid,
   input wire logic [18:0] word_address,
   input wire logic        extra_address_bit,
   input wire logic        select_low_active,
   input wire logic        select_high_active,
   input wire logic        out_en_n,
   input wire logic        write_en_n,
   input wire logic        upper_lane_en_n,
   input wire logic        lower_lane_en_n,
   input wire logic        width_sel,
   input wire logic        data_lines_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_wr_body;
      write_en_n && data_lines_oe ##1 !write_en_n ##1 write_en_n && data_lines_oe
      ##1 !data_lines_oe && req_ready;
   endsequence
   property p_rd_lat; s_take ##0 !req_write |=> (!rsp_valid)[*3] ##1 rsp_valid; endproperty
   property p_wr_seq; s_take ##0 req_write |=> s_wr_body; endproperty
   property p_we_sel;
      !write_en_n |-> !select_low_active && select_high_active && data_lines_oe && out_en_n;
   endproperty
   property p_rd_pins;
      s_take ##0 !req_write |=> (!out_en_n && write_en_n && !data_lines_oe && !select_low_active
         && select_high_active)[*3] ##1 (out_en_n && select_low_active);
   endproperty
   property p_idle; req_ready |-> select_low_active && !select_high_active && !data_lines_oe; endproperty
   property p_lanes;
      s_take ##0 req_write && width_sel && wide_mode
         |=> {upper_lane_en_n, lower_lane_en_n} == ~$past(req_lanes);
   endproperty
   property p_byte;
      s_take ##0 !width_sel && !wide_mode |=> !upper_lane_en_n && !lower_lane_en_n
         && {extra_address_bit, word_address} == $past(req_addr);
   endproperty
   property p_addr;
      s_take ##0 width_sel && wide_mode |=> !extra_address_bit && word_address == 19'($past(req_addr));
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late or early");
   a_wr_seq: assert property (p_wr_seq) else $error("write strobe sequence wrong");
   a_we_sel: assert property (p_we_sel) else $error("strobe low without select");
   a_rd_pins: assert property (p_rd_pins) else $error("read pins wrong");
   a_idle: assert property (p_idle) else $error("idle but selected");
   a_lanes: assert property (p_lanes) else $error("lane enables wrong");
   a_byte: assert property (p_byte) else $error("byte mode pins wrong");
   a_addr: assert property (p_addr) else $error("word address wrong");
endmodule : sram_host_chk
bind sram_host_ctl sram_host_chk chk_inst (
   .clk_sys            (clk_sys),
   .resetn             (resetn),
   .wide_mode          (wide_mode),
   .req_valid          (req_valid),
   .req_ready          (req_ready),
   .req_write          (req_write),
   .req_addr           (req_addr),
   .req_lanes          (req_lanes),
   .rsp_valid          (rsp_valid),
   .word_address       (word_address),
   .extra_address_bit  (extra_address_bit),
   .select_low_active  (select_low_active),
   .select_high_active (select_high_active),
   .out_en_n           (out_en_n),
   .write_en_n         (write_en_n),
   .upper_lane_en_n    (upper_lane_en_n),
   .lower_lane_en_n    (lower_lane_en_n),
   .width_sel          (width_sel),
   .data_lines_oe      (data_lines_oe)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 0, resetn = 0, wide_mode = 1, req_valid = 0, req_write = 0;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0]  req_lanes = 2'h0;
   logic req_ready, rsp_valid, extra_address_bit, select_low_active, select_high_active, out_en_n;
   logic write_en_n, upper_lane_en_n, lower_lane_en_n, width_sel, data_lines_oe;
   logic [15:0] rsp_rdata, data_lines_o, dq, data_lines_i;
   logic [18:0] word_address;
   integer seed = 32'h6F76;
   int n_mismatch = 0, n_compared = 0;
   logic [15:0] q [$];
   logic [15:0] wref [int];
   logic [19:0] ra;
   assign data_lines_i = data_lines_oe ? data_lines_o : dq;
   initial forever #25 clk_sys = ~clk_sys;
   sram_host_ctl sram_host_ctl_inst (
      .clk_sys            (clk_sys),
      .resetn             (resetn),
      .wide_mode          (wide_mode),
      .req_valid          (req_valid),
      .req_ready          (req_ready),
      .req_write          (req_write),
      .req_addr           (req_addr),
      .req_wdata          (req_wdata),
      .req_lanes          (req_lanes),
      .rsp_valid          (rsp_valid),
      .rsp_rdata          (rsp_rdata),
      .word_address       (word_address),
      .extra_address_bit  (extra_address_bit),
      .select_low_active  (select_low_active),
      .select_high_active (select_high_active),
      .out_en_n           (out_en_n),
      .write_en_n         (write_en_n),
      .upper_lane_en_n    (upper_lane_en_n),
      .lower_lane_en_n    (lower_lane_en_n),
      .width_sel          (width_sel),
      .data_lines_i       (data_lines_i),
      .data_lines_o       (data_lines_o),
      .data_lines_oe      (data_lines_oe)
   );
   sram_dev_model #(.ACC_NS(40)) sram_dev_model_inst (.clk_sys(clk_sys),
      .word_address(word_address), .extra_address_bit(extra_address_bit),
      .select_low_active(select_low_active), .select_high_active(select_high_active),
      .out_en_n(out_en_n), .write_en_n(write_en_n), .upper_lane_en_n(upper_lane_en_n),
      .lower_lane_en_n(lower_lane_en_n), .width_sel(width_sel), .bus(data_lines_i), .dq(dq));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task op(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] l);
      int k;
      int key;
      logic [15:0] m;
      @(posedge clk_sys) #5;
      req_valid = 1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_lanes = l;
      k = 0;
      do begin @(posedge clk_sys); k++; end while (req_ready !== 1'b1 && k < 20);
      if (k >= 20) n_mismatch++;
      #5 req_valid = 0;
      key = wide_mode ? int'(a[18:0]) : 32'h100000 | int'(a);
      m = wref.exists(key) ? wref[key] : 16'h0000;
      if (w) begin
         if (l[0] || !wide_mode) m[7:0] = d[7:0];
         if (l[1] && wide_mode) m[15:8] = d[15:8];
         wref[key] = m;
      end else if (wide_mode) q.push_back({l[1] ? m[15:8] : 8'h00, l[0] ? m[7:0] : 8'h00});
      else q.push_back({8'h00, m[7:0]});
   endtask : op
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (rsp_valid === 1'b1) chk(rsp_rdata, q.size() > 0 ? q.pop_front() : 16'hXXXX);
   end
   initial begin
      #(3000 * 50);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      #5 resetn = 1;
      chk({8'h00, req_ready, select_low_active, select_high_active, out_en_n, write_en_n,
         upper_lane_en_n, lower_lane_en_n, data_lines_oe}, 16'h00DE);
      for (int i = 0; i < 4; i++) op(1, 20'h00123, 16'(16'h1357 * (i + 1)), 2'(i));
      for (int i = 0; i < 4; i++) op(0, 20'h00123, 16'h0000, 2'(i));
      // a write with no lane enabled must leave the word alone
      op(1, 20'h00123, 16'hFFFF, 2'h0);
      op(0, 20'h00123, 16'h0000, 2'h3);
      $display("test lanes done");
      repeat (20) begin
         ra = {1'b0, 19'($random(seed))};
         op(1, ra, 16'($random(seed)), 2'h3);
         op(1, ra, 16'($random(seed)), 2'($random(seed)));
         op(0, ra, 16'($random(seed)), 2'($random(seed)));
      end
      $display("test random done");
      // the strap only moves once the last access has finished
      @(posedge clk_sys) #5 wide_mode = 0;
      repeat (6) @(posedge clk_sys);
      chk({15'h0000, width_sel}, 16'h0000);
      op(1, 20'h80077, 16'hBE3C, 2'h0);
      op(1, 20'h00077, 16'h12A1, 2'h3);
      op(0, 20'h80077, 16'h0000, 2'h0);
      op(0, 20'h00077, 16'h0000, 2'h1);
      @(posedge clk_sys) #5 wide_mode = 1;
      repeat (6) @(posedge clk_sys);
      chk({15'h0000, width_sel}, 16'h0001);
      op(0, 20'h00123, 16'h0000, 2'h3);
      $display("test byte mode done");
      repeat (8) @(posedge clk_sys);
      chk(16'(q.size()), 16'h0000);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
